//--- core/plvd_pkg.sv
package plvd_pkg;
   // ****************************************
   // widths and scaling
   // ****************************************
   localparam int ADC_W = 12;
   localparam int PCT_W = 16;
   localparam logic [15:0] PCT_FULL = 16'h2710;
   localparam logic [11:0] ADC_FULL = 12'hFFF;
   localparam logic [11:0] ADC_4MA = 12'h333;
   localparam logic [11:0] ADC_OPEN = 12'h199;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ = 10000000;
   localparam int SAMPLE_US = 1000;
   localparam int SAMPLE_CYC = CLK_HZ / 1000000 * SAMPLE_US;
   localparam int PWM_STEPS = 64;
   localparam int PWM_DIV_MIN = 60;
   localparam int PWM_DIV_MAX = 2561;
   localparam logic [11:0] PWM_DIV_RST = 12'h140;
   // ****************************************
   // current span in milliamperes
   // ****************************************
   localparam logic [11:0] CUR_MIN_MA = 12'h1F4;
   localparam logic [11:0] CUR_MAX_MA = 12'hA28;
   localparam logic [15:0] RAMP_RST_MS = 16'h0064;
   typedef enum logic [1:0] {PLVD_IDLE, PLVD_RUN, PLVD_EMERG} plvd_mode_t;
endpackage

//--- core/plvd_pwm.sv
`timescale 1ns/100ps
`default_nettype none
module plvd_pwm (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic [11:0] div_in,
   input wire logic [5:0] duty_in,
   input wire logic [5:0] dither_amp_in,
   input wire logic run_in,
   output logic pwm_out
);
   logic [11:0] pre_r;
   logic [5:0] slot_r;
   logic dith_r;
   logic [6:0] duty_eff;
   logic [11:0] div_c;
   // ****************************************
   // divider clamps the frequency span
   // ****************************************
   always_comb begin
      div_c = div_in;
      if (div_in < 12'(plvd_pkg::PWM_DIV_MIN)) div_c = 12'(plvd_pkg::PWM_DIV_MIN);
      if (div_in > 12'(plvd_pkg::PWM_DIV_MAX)) div_c = 12'(plvd_pkg::PWM_DIV_MAX);
      if (dith_r) duty_eff = {1'b0, duty_in} + {1'b0, dither_amp_in};
      else if (duty_in > dither_amp_in) duty_eff = {1'b0, duty_in - dither_amp_in};
      else duty_eff = 7'h00;
   end
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pre_r <= 12'h000;
         slot_r <= 6'h00;
         dith_r <= 1'b0;
         pwm_out <= 1'b0;
      end else begin
         if (pre_r >= div_c - 12'h001) begin
            pre_r <= 12'h000;
            slot_r <= slot_r + 6'h01;
            if (slot_r == 6'h3F) dith_r <= ~dith_r;
         end else begin
            pre_r <= pre_r + 12'h001;
         end
         // dither alternates the duty every period
         pwm_out <= run_in && ({1'b0, slot_r} < duty_eff);
      end
   end
endmodule
`default_nettype wire

//--- core/plvd_top.sv
// Summary of operation
// - ready only when enabled and error free
// - lamp mirrors ready output
// - open current-loop sensor flags error
// - start runs controller using analogue command
// - enable activates closed-loop power stage
// - open or shorted output is error
// - current setpoint 0.5 to 2.6 A
// - inputs scaled linearly to 0..100 percent
// - command fed forward, loop adds correction
// - ramp applied to command changes
// - dead-band compensation sets span and position
// - sample period, pwm, dither configurable
// - failure forces emergency value unless disabled
// - ramp times in sample periods per full step (ms at the default 1 ms period)
// - max limit, min offset above trigger
`timescale 1ns/100ps
`default_nettype none
module plvd_top (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic enable_in,
   input wire logic start_in,
   input wire logic [11:0] cmd_adc_in,
   input wire logic cmd_is_current_in,
   input wire logic [11:0] fb_adc_in,
   input wire logic fb_is_current_in,
   input wire logic out_open_in,
   input wire logic out_short_in,
   input wire logic [15:0] ramp_up_ms_in,
   input wire logic [15:0] ramp_down_ms_in,
   input wire logic [15:0] out_max_in,
   input wire logic [15:0] out_min_in,
   input wire logic [15:0] trigger_in,
   input wire logic [11:0] cur_nom_ma_in,
   input wire logic [15:0] sample_cyc_in,
   input wire logic [11:0] pwm_div_in,
   input wire logic [5:0] dither_amp_in,
   input wire logic [3:0] kp_shift_in,
   input wire logic [15:0] emergency_output_value_in,
   input wire logic emergency_en_in,
   output logic ready_out,
   output logic ready_led_out,
   output logic error_out,
   output logic pwm_out,
   output logic [15:0] cmd_pct_out,
   output logic [15:0] out_pct_out
);
   plvd_pkg::plvd_mode_t mode_r;
   logic [15:0] tick_r, cmd_r, fb_r, ramp_r, corr_r, out_r;
   logic [15:0] upstep_r, dnstep_r;
   logic sample_stb, err_c, sens_err_c;
   logic [15:0] cmd_pct, fb_pct, dead_c, lim_c;
   logic [11:0] cur_c;
   logic [5:0] duty_c;
   logic [31:0] cur_prod;

   // ****************************************
   // scaling of voltage or 4-20 mA inputs
   // ****************************************
   function automatic logic [15:0] scale_pct(input logic [11:0] adc, input logic is_cur);
      logic [11:0] span;
      logic [11:0] v;
      logic [27:0] p;
      span = plvd_pkg::ADC_FULL;
      v = adc;
      if (is_cur) begin
         span = plvd_pkg::ADC_FULL - plvd_pkg::ADC_4MA;
         v = (adc > plvd_pkg::ADC_4MA) ? adc - plvd_pkg::ADC_4MA : 12'h000;
      end
      p = {16'h0000, v} * 28'(plvd_pkg::PCT_FULL);
      p = p / {16'h0000, span};
      scale_pct = (p > 28'(plvd_pkg::PCT_FULL)) ? plvd_pkg::PCT_FULL : p[15:0];
   endfunction

   function automatic logic [15:0] ms_step(input logic [15:0] ms);
      // percent change per sample period (1 ms at the default period) for a full-span step
      ms_step = (ms == 16'h0000) ? plvd_pkg::PCT_FULL : plvd_pkg::PCT_FULL / ms;
      if (ms_step == 16'h0000) ms_step = 16'h0001;
   endfunction

   always_comb begin
      cmd_pct = scale_pct(cmd_adc_in, cmd_is_current_in);
      fb_pct = scale_pct(fb_adc_in, fb_is_current_in);
      sens_err_c = fb_is_current_in && (fb_adc_in < plvd_pkg::ADC_OPEN);
      err_c = sens_err_c || out_open_in || out_short_in;
      // dead band: below trigger output zero, above it offset by min and cap at max
      if (corr_r < trigger_in) dead_c = 16'h0000;
      else dead_c = out_min_in + 16'((32'(corr_r) * 32'(out_max_in - out_min_in))
         / 32'(plvd_pkg::PCT_FULL));
      lim_c = (dead_c > out_max_in) ? out_max_in : dead_c;
      cur_c = cur_nom_ma_in;
      if (cur_nom_ma_in < plvd_pkg::CUR_MIN_MA) cur_c = plvd_pkg::CUR_MIN_MA;
      if (cur_nom_ma_in > plvd_pkg::CUR_MAX_MA) cur_c = plvd_pkg::CUR_MAX_MA;
      cur_prod = (32'(out_r) * 32'(cur_c) * 32'(plvd_pkg::PWM_STEPS))
         / (32'(plvd_pkg::PCT_FULL) * 32'(plvd_pkg::CUR_MAX_MA));
      duty_c = (cur_prod > 32'h3F) ? 6'h3F : cur_prod[5:0];
      sample_stb = (tick_r == 16'h0000);
   end

   // ****************************************
   // sample period divider
   // ****************************************
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) tick_r <= 16'h0000;
      else if (tick_r == 16'h0000)
         tick_r <= (sample_cyc_in == 16'h0000) ? 16'(plvd_pkg::SAMPLE_CYC - 1)
            : sample_cyc_in - 16'h0001;
      else tick_r <= tick_r - 16'h0001;
   end

   // ****************************************
   // mode and error state
   // ****************************************
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) mode_r <= plvd_pkg::PLVD_IDLE;
      else begin
         case (mode_r)
            plvd_pkg::PLVD_IDLE: if (enable_in && !err_c) mode_r <= plvd_pkg::PLVD_RUN;
               else if (emergency_en_in) mode_r <= plvd_pkg::PLVD_EMERG;
            plvd_pkg::PLVD_RUN: if (!enable_in || err_c)
               mode_r <= emergency_en_in ? plvd_pkg::PLVD_EMERG : plvd_pkg::PLVD_IDLE;
            plvd_pkg::PLVD_EMERG: if (enable_in && !err_c) mode_r <= plvd_pkg::PLVD_RUN;
               else if (!emergency_en_in) mode_r <= plvd_pkg::PLVD_IDLE;
            default: mode_r <= plvd_pkg::PLVD_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ready_out <= 1'b0;
         ready_led_out <= 1'b0;
         error_out <= 1'b0;
      end else begin
         ready_out <= enable_in && !err_c;
         ready_led_out <= enable_in && !err_c;
         error_out <= err_c;
      end
   end

   // ****************************************
   // command capture and ramp
   // ****************************************
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmd_r <= 16'h0000;
         fb_r <= 16'h0000;
         upstep_r <= plvd_pkg::PCT_FULL / plvd_pkg::RAMP_RST_MS;
         dnstep_r <= plvd_pkg::PCT_FULL / plvd_pkg::RAMP_RST_MS;
      end else if (sample_stb) begin
         // the command is only taken over while start is held; otherwise it holds
         if (start_in) cmd_r <= cmd_pct;
         fb_r <= fb_pct;
         upstep_r <= ms_step(ramp_up_ms_in);
         dnstep_r <= ms_step(ramp_down_ms_in);
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) ramp_r <= 16'h0000;
      else if (sample_stb) begin
         if (cmd_r > ramp_r)
            ramp_r <= (cmd_r - ramp_r > upstep_r) ? ramp_r + upstep_r : cmd_r;
         else if (cmd_r < ramp_r)
            ramp_r <= (ramp_r - cmd_r > dnstep_r) ? ramp_r - dnstep_r : cmd_r;
      end
   end

   // ****************************************
   // feed-forward plus linearity correction
   // ****************************************
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) corr_r <= 16'h0000;
      else if (mode_r != plvd_pkg::PLVD_RUN || !start_in) corr_r <= ramp_r;
      else if (sample_stb) begin
         // proportional trim only; saturates so it cannot wrap past the span
         logic signed [17:0] e;
         logic signed [17:0] s;
         e = 18'(signed'({2'b00, ramp_r})) - 18'(signed'({2'b00, fb_r}));
         s = 18'(signed'({2'b00, ramp_r})) + (e >>> kp_shift_in);
         if (s < 0) corr_r <= 16'h0000;
         else if (s > 18'(plvd_pkg::PCT_FULL)) corr_r <= plvd_pkg::PCT_FULL;
         else corr_r <= s[15:0];
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         out_r <= 16'h0000;
         cmd_pct_out <= 16'h0000;
         out_pct_out <= 16'h0000;
      end else begin
         case (mode_r)
            plvd_pkg::PLVD_RUN: out_r <= lim_c;
            plvd_pkg::PLVD_EMERG: out_r <= emergency_output_value_in;
            default: out_r <= 16'h0000;
         endcase
         cmd_pct_out <= ramp_r;
         out_pct_out <= out_r;
      end
   end

   plvd_pwm u_pwm (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .div_in(pwm_div_in),
      .duty_in(duty_c),
      .dither_amp_in(dither_amp_in),
      .run_in(mode_r != plvd_pkg::PLVD_IDLE),
      .pwm_out(pwm_out)
   );
endmodule
`default_nettype wire

//--- bench/plvd_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module plvd_monitor (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic enable_in,
   input wire logic start_in,
   input wire logic [11:0] fb_adc_in,
   input wire logic fb_is_current_in,
   input wire logic out_open_in,
   input wire logic out_short_in,
   input wire logic [15:0] ramp_up_ms_in,
   input wire logic [15:0] ramp_down_ms_in,
   input wire logic [15:0] out_max_in,
   input wire logic [15:0] emergency_output_value_in,
   input wire logic emergency_en_in,
   input wire logic ready_out,
   input wire logic ready_led_out,
   input wire logic error_out,
   input wire logic [15:0] cmd_pct_out,
   input wire logic [15:0] out_pct_out
);
   // ****
   // port relations
   // ****
   logic fault;
   assign fault = (fb_is_current_in && fb_adc_in < plvd_pkg::ADC_OPEN) || out_open_in || out_short_in;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // first edge after release still shows reset values, hence the guard
   a_ready_gate: assert property ($past(rst_n_in) |-> ready_out == $past(enable_in && !fault))
      else $error("ready wrong");
   a_led_mirror: assert property (ready_led_out == ready_out)
      else $error("lamp wrong");
   a_sensor_open: assert property (fb_is_current_in && fb_adc_in < plvd_pkg::ADC_OPEN |=> error_out)
      else $error("open sensor missed");
   a_wire_fault: assert property (out_open_in || out_short_in |=> error_out && !ready_out)
      else $error("wire fault missed");
   a_cmd_hold: assert property ((!start_in && ramp_up_ms_in == 16'h0000 && ramp_down_ms_in == 16'h0000)[*4] |-> $stable(cmd_pct_out))
      else $error("command moved");
   a_emerg_value: assert property ((!enable_in && emergency_en_in && $stable(emergency_output_value_in))[*4] |-> out_pct_out == emergency_output_value_in)
      else $error("emergency value wrong");
   a_max_cap: assert property ((enable_in && !error_out && $stable(out_max_in))[*4] |-> out_pct_out <= out_max_in)
      else $error("output above max");
   a_error_block: assert property (error_out |-> !ready_led_out)
      else $error("lamp on with error");
endmodule
`default_nettype wire

//--- bench/plvd_valve_model.sv
`timescale 1ns/100ps
`default_nettype none
module plvd_valve_model (
   input wire logic clk_sys_in,
   input wire logic pwm_in,
   output logic [11:0] fb_adc_out
);
   // ****
   // pressure lags the drive duty, sensor reads it
   // ****
   logic [19:0] press_r = 20'h00000;
   always @(posedge clk_sys_in) begin
      press_r <= press_r - (press_r >> 8) + (pwm_in ? 20'h00FFF : 20'h00000);
   end
   assign fb_adc_out = press_r[19:8];
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, w) begin comparisons++; if ((g) !== (w)) begin error_cnt++; $display("BAD %0t got %0h want %0h", $time, g, w); end end
module testbench;
   logic clk_sys_in = 1'h0, rst_n_in = 1'h0, enable_in = 1'h0, start_in = 1'h0, fb_force = 1'h1;
   logic cmd_is_current_in = 1'h0, fb_is_current_in = 1'h0, out_open_in = 1'h0;
   logic out_short_in = 1'h0, emergency_en_in = 1'h0, ready_out, ready_led_out, error_out, pwm_out;
   logic [11:0] cmd_adc_in = 12'h000, fb_set = 12'h000, pwm_div_in = 12'h03C, fb_adc_in, fb_model;
   logic [11:0] cur_nom_ma_in = 12'h064;
   logic [15:0] ramp_up_ms_in = 16'h0000, ramp_down_ms_in = 16'h0000, out_max_in = 16'h2710;
   logic [15:0] out_min_in = 16'h0000, trigger_in = 16'h0000, sample_cyc_in = 16'h0064;
   logic [15:0] emergency_output_value_in = 16'h1234, cmd_pct_out, out_pct_out;
   logic [5:0] dither_amp_in = 6'h00;
   logic [3:0] kp_shift_in = 4'hF;
   int error_cnt = 0;
   int comparisons = 0;
   time t0;
   // ****
   // enable, current sensor, feedback, open/short -> ready/error
   // ****
   logic [17:0] rows [7] = '{
      {1'h1, 1'h0, 12'h000, 2'h0, 2'h2}, {1'h0, 1'h0, 12'h000, 2'h0, 2'h0},
      {1'h1, 1'h1, 12'h198, 2'h0, 2'h1}, {1'h1, 1'h1, 12'h199, 2'h0, 2'h2},
      {1'h1, 1'h0, 12'h800, 2'h2, 2'h1}, {1'h0, 1'h0, 12'h800, 2'h1, 2'h1},
      {1'h1, 1'h0, 12'hFFF, 2'h0, 2'h2}};
   assign fb_adc_in = fb_force ? fb_set : fb_model;
   always #50 clk_sys_in = ~clk_sys_in;
   plvd_top dut_u (.*);
   plvd_valve_model vm_u (.clk_sys_in(clk_sys_in), .pwm_in(pwm_out), .fb_adc_out(fb_model));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
      #10;
   endtask
   task automatic wrap_up;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      cyc(10);
      rst_n_in = 1'h1;
      foreach (rows[i]) begin
         {enable_in, fb_is_current_in, fb_set, out_open_in, out_short_in} = rows[i][17:2];
         cyc(2);
         `CHK({ready_out, error_out}, rows[i][1:0])
         `CHK(ready_led_out, rows[i][1])
      end
      // ****
      // scaling, feed-forward, start gating
      // ****
      start_in = 1'h1;
      cmd_is_current_in = 1'h1;
      cmd_adc_in = 12'hFFF;
      cyc(400);
      `CHK(cmd_pct_out, 16'h2710)
      `CHK(out_pct_out, 16'h2710)
      start_in = 1'h0;
      cmd_adc_in = 12'h333;
      cyc(400);
      `CHK(cmd_pct_out, 16'h2710)
      start_in = 1'h1;
      cyc(400);
      `CHK(cmd_pct_out, 16'h0000)
      cmd_is_current_in = 1'h0;
      cmd_adc_in = 12'hFFF;
      out_max_in = 16'h1388;
      cyc(400);
      `CHK(out_pct_out, 16'h1388)
      out_max_in = 16'h2710;
      trigger_in = 16'h03E8;
      out_min_in = 16'h01F4;
      cmd_adc_in = 12'h100;
      cyc(400);
      `CHK(out_pct_out, 16'h0000)
      `CHK(cmd_pct_out > 16'h0000, 1'h1)
      trigger_in = 16'h0000;
      out_min_in = 16'h0000;
      // ****
      // ramp, pwm period at clamped divider, emergency
      // ****
      ramp_up_ms_in = 16'h000A;
      cmd_adc_in = 12'hFFF;
      cyc(300);
      `CHK(cmd_pct_out < 16'h2710, 1'h1)
      cmd_adc_in = 12'h000;
      cyc(400);
      `CHK(cmd_pct_out, 16'h0000)
      fb_force = 1'h0;
      cmd_adc_in = 12'h800;
      pwm_div_in = 12'h010;
      cyc(4000);
      @(posedge pwm_out);
      t0 = $time;
      @(posedge pwm_out);
      `CHK($time - t0, 64'h5DC00)
      // current below the span is raised to its floor: six slots high
      t0 = $time;
      @(negedge pwm_out);
      `CHK($time - t0, 64'h8CA0)
      #10;
      cur_nom_ma_in = 12'hFFF;
      cyc(4000);
      @(posedge pwm_out);
      t0 = $time;
      @(negedge pwm_out);
      `CHK($time - t0, 64'h2EE00)
      #10;
      enable_in = 1'h0;
      emergency_en_in = 1'h1;
      cyc(6);
      `CHK(out_pct_out, 16'h1234)
      enable_in = 1'h1;
      out_short_in = 1'h1;
      cyc(6);
      `CHK({error_out, out_pct_out}, {1'h1, 16'h1234})
      rst_n_in = 1'h0;
      cyc(2);
      `CHK({ready_out, out_pct_out}, 17'h00000)
      rst_n_in = 1'h1;
      cyc(4);
      `CHK({ready_out, error_out}, 2'h1)
      wrap_up();
   end
   initial begin
      repeat (60000) @(posedge clk_sys_in);
      error_cnt++;
      wrap_up();
   end
endmodule
bind plvd_top plvd_monitor mon_u (.*);
`default_nettype wire
